// ---- inc/wkm_pkg.sv ----
// constants and types shared by the wake input monitor files
package wkm_pkg;

    // ------------------------------------------------------------
    // clock and filter timing
    // ------------------------------------------------------------
    localparam int WKM_CLK_NS = 20;
    localparam int WKM_FLT_SHORT_NS = 16000;
    localparam int WKM_FLT_LONG_NS = 64000;
    // filter times are least times, so round up to whole cycles
    localparam int WKM_FLT_SHORT_CYC =
        (WKM_FLT_SHORT_NS + WKM_CLK_NS - 1) / WKM_CLK_NS;
    localparam int WKM_FLT_LONG_CYC =
        (WKM_FLT_LONG_NS + WKM_CLK_NS - 1) / WKM_CLK_NS;
    localparam int WKM_CNT_W = 12;
    localparam logic [WKM_CNT_W-1:0] WKM_LIM_SHORT =
        WKM_CNT_W'(WKM_FLT_SHORT_CYC);
    localparam logic [WKM_CNT_W-1:0] WKM_LIM_LONG =
        WKM_CNT_W'(WKM_FLT_LONG_CYC);

    // ------------------------------------------------------------
    // pin counts and field layout (two bits per pin, pin k at 2k)
    // ------------------------------------------------------------
    localparam int WKM_NPIN = 3;
    localparam int WKM_NAFO = 2;
    localparam int WKM_FLD_W = 2;

    // pull selection codes
    localparam logic [1:0] WKM_PULL_NONE = 2'h0;
    localparam logic [1:0] WKM_PULL_DOWN = 2'h1;
    localparam logic [1:0] WKM_PULL_UP = 2'h2;
    localparam logic [1:0] WKM_PULL_AUTO = 2'h3;

    // detection codes
    localparam logic [1:0] WKM_DET_STATIC_SHORT = 2'h0;
    localparam logic [1:0] WKM_DET_STATIC_LONG = 2'h1;
    localparam logic [1:0] WKM_DET_CYCLIC_T1 = 2'h2;
    localparam logic [1:0] WKM_DET_CYCLIC_T2 = 2'h3;

    // reset values
    localparam logic [5:0] WKM_PULL_RST = 6'h00;
    localparam logic [5:0] WKM_DET_RST = 6'h00;
    localparam logic [2:0] WKM_WEN_RST = 3'h0;
    localparam logic WKM_MEAS_RST = 1'b0;

    // device operating mode, driven by the mode controller
    typedef enum logic [1:0] {
        WKM_MODE_NORMAL,
        WKM_MODE_STOP,
        WKM_MODE_SLEEP,
        WKM_MODE_FAILSAFE
    } wkm_mode_e;

    // software configuration held by the block
    typedef struct packed {
        logic [5:0] pull;
        logic [5:0] det;
        logic [2:0] wen;
        logic meas;
    } wkm_cfg_s;

endpackage

// ---- core/wkm_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module wkm_sync #(
    parameter int W = 1
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // asynchronous in, synchronous out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // first stage is read only by the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- core/wkm_filter.sv ----
// per-input glitch filter with restart on every crossing
`timescale 1ns/100ps
`default_nettype none
module wkm_filter #(
    parameter int CNT_W = 12
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // synchronised level, sensing window and filter length
    input wire logic i_level,
    input wire logic i_active,
    input wire logic [CNT_W-1:0] i_limit,
    // accepted level and one-cycle edge pulse
    output logic o_level,
    output logic o_edge
);
    logic [CNT_W-1:0] cnt, next_cnt;
    logic last, next_last, next_level, next_edge;

    if (CNT_W < 2) begin : g_chk
        $error("wkm_filter: CNT_W too small");
    end

    // outside the window the accepted level is frozen (last sample)
    always_comb begin
        next_cnt = cnt;
        next_last = last;
        next_level = o_level;
        next_edge = 1'b0;
        if (!i_active) begin
            next_cnt = '0;
            next_last = i_level;
        end else if (i_level != last) begin
            next_last = i_level; // crossing restarts filter
            next_cnt = '0;
        end else if (last != o_level) begin
            if (cnt >= i_limit - 1'b1) begin
                next_level = last; // either direction counts
                next_edge = 1'b1;
                next_cnt = '0;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end else begin
            next_cnt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt <= '0;
            last <= 1'b0;
            o_level <= 1'b0;
            o_edge <= 1'b0;
        end else if (i_ce) begin
            cnt <= next_cnt;
            last <= next_last;
            o_level <= next_level;
            o_edge <= next_edge;
        end
    end

    // an edge always flips the accepted level; a frozen cycle holds both
    property p_edge_flips;
        @(posedge i_clk) disable iff (i_rst)
        (o_edge && $past(i_ce)) |-> (o_level != $past(o_level));
    endproperty
    a_edge_flips: assert property (p_edge_flips)
        else $error("edge without level change");

    // a crossing just seen blocks acceptance on the next cycle
    property p_restart;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_active && i_level != last) |=> !o_edge;
    endproperty
    a_restart: assert property (p_restart)
        else $error("edge accepted right after a crossing");
endmodule
`default_nettype wire

// ---- core/wkm_top.sv ----
// wake input monitor: filters, pulls, status and measurement gating
`timescale 1ns/100ps
`default_nettype none
module wkm_top
    import wkm_pkg::*;
(
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // asynchronous pins
    input wire logic [WKM_NPIN-1:0] I_WAKE_PIN,
    input wire logic [WKM_NAFO-1:0] I_AFO_PIN,
    // device state and timer windows
    input wire wkm_mode_e I_MODE,
    input wire logic [1:0] I_TIMER_WIN,
    input wire logic [WKM_NAFO-1:0] I_AFO_WAKE_EN,
    input wire logic I_SLEEP_CMD,
    // configuration writes
    input wire logic I_PULL_WR,
    input wire logic [5:0] I_PULL_DATA,
    input wire logic I_DET_WR,
    input wire logic [5:0] I_DET_DATA,
    input wire logic I_WEN_WR,
    input wire logic [2:0] I_WEN_DATA,
    input wire logic I_MEAS_WR,
    input wire logic I_MEAS_DATA,
    // status clears, one bit per flag
    input wire logic [WKM_NPIN-1:0] I_STAT_A_CLR,
    input wire logic [WKM_NAFO-1:0] I_STAT_B_CLR,
    // configuration readback
    output logic [5:0] O_PULL_CFG,
    output logic [5:0] O_DET_CFG,
    output logic [2:0] O_WEN_CFG,
    output logic O_MEAS_CFG,
    // status
    output logic [WKM_NPIN-1:0] O_STATUS_A,
    output logic [WKM_NAFO-1:0] O_STATUS_B,
    output logic [WKM_NPIN-1:0] O_LEVEL,
    // analogue controls
    output logic [WKM_NPIN-1:0] O_PULL_UP_EN,
    output logic [WKM_NPIN-1:0] O_PULL_DOWN_EN,
    output logic O_SWITCH_CLOSED,
    // event pulses
    output logic O_INT_REQ,
    output logic O_WAKE_REQ,
    output logic O_SPI_FAIL,
    output logic O_RESTART_REQ
);
    localparam int NIN = WKM_NPIN + WKM_NAFO;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    wkm_cfg_s cfg, next_cfg;

    // writes are stored even while measurement ignores them
    always_comb begin
        next_cfg = cfg;
        if (I_PULL_WR) begin
            next_cfg.pull = I_PULL_DATA;
        end
        if (I_DET_WR) begin
            next_cfg.det = I_DET_DATA;
        end
        if (I_WEN_WR) begin
            next_cfg.wen = I_WEN_DATA;
        end
        if (I_MEAS_WR) begin
            next_cfg.meas = I_MEAS_DATA;
        end
    end

    // reset leaves pins floating and measurement off
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            cfg.pull <= WKM_PULL_RST;
            cfg.det <= WKM_DET_RST;
            cfg.wen <= WKM_WEN_RST;
            cfg.meas <= WKM_MEAS_RST;
        end else if (I_CE) begin
            cfg <= next_cfg;
        end
    end

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic [NIN-1:0] pin_sync;
    logic [NIN-1:0] flt_active;
    logic [NIN-1:0] flt_level;
    logic [NIN-1:0] flt_edge;
    logic [WKM_CNT_W-1:0] flt_limit [NIN];
    logic [WKM_NPIN-1:0] gated;
    logic active_mode;
    logic low_power;

    // pins are asynchronous to the oscillator clock
    wkm_sync #(
        .W(NIN)
    ) u_sync (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_async({I_AFO_PIN, I_WAKE_PIN}),
        .o_sync(pin_sync)
    );

    // measurement removes pins 0 and 1 from wake duty
    always_comb begin
        gated = {1'b0, {2{cfg.meas}}};
        active_mode = (I_MODE == WKM_MODE_NORMAL) ||
                      (I_MODE == WKM_MODE_STOP);
        low_power = (I_MODE == WKM_MODE_SLEEP) ||
                    (I_MODE == WKM_MODE_FAILSAFE);
    end

    // sensing window and filter length per wake pin
    always_comb begin
        for (int k = 0; k < WKM_NPIN; k++) begin
            case (cfg.det[k*WKM_FLD_W +: WKM_FLD_W])
                WKM_DET_STATIC_SHORT: begin
                    flt_active[k] = 1'b1;
                    flt_limit[k] = WKM_LIM_SHORT;
                end
                WKM_DET_STATIC_LONG: begin
                    flt_active[k] = 1'b1;
                    flt_limit[k] = WKM_LIM_LONG;
                end
                WKM_DET_CYCLIC_T1: begin
                    flt_active[k] = I_TIMER_WIN[0];
                    flt_limit[k] = WKM_LIM_SHORT;
                end
                WKM_DET_CYCLIC_T2: begin
                    flt_active[k] = I_TIMER_WIN[1];
                    flt_limit[k] = WKM_LIM_SHORT;
                end
                default: begin
                    flt_active[k] = 1'b1;
                    flt_limit[k] = WKM_LIM_SHORT;
                end
            endcase
            if (gated[k]) begin
                flt_active[k] = 1'b0;
            end
        end
        // alternate outputs: fixed static short filter
        for (int j = 0; j < WKM_NAFO; j++) begin
            flt_active[WKM_NPIN+j] = I_AFO_WAKE_EN[j];
            flt_limit[WKM_NPIN+j] = WKM_LIM_SHORT;
        end
    end

    // one filter per input, timed in clock cycles
    for (genvar g = 0; g < NIN; g++) begin : g_flt
        wkm_filter #(
            .CNT_W(WKM_CNT_W)
        ) u_flt (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_ce(I_CE),
            .i_level(pin_sync[g]),
            .i_active(flt_active[g]),
            .i_limit(flt_limit[g]),
            .o_level(flt_level[g]),
            .o_edge(flt_edge[g])
        );
    end

    // ------------------------------------------------------------
    // status and event generation
    // ------------------------------------------------------------
    logic [WKM_NPIN-1:0] src_a, next_stat_a, next_lvl;
    logic [WKM_NAFO-1:0] src_b, next_stat_b;
    logic next_int, next_wake;

    // set beats a clear landing in the same cycle
    always_comb begin
        src_a = flt_edge[WKM_NPIN-1:0] & cfg.wen & ~gated;
        src_b = flt_edge[NIN-1:WKM_NPIN] & I_AFO_WAKE_EN;
        next_stat_a = (O_STATUS_A & ~I_STAT_A_CLR) | src_a;
        next_stat_b = (O_STATUS_B & ~I_STAT_B_CLR) | src_b;
        next_int = active_mode && ((|src_a) || (|src_b));
        next_wake = low_power && ((|src_a) || (|src_b));
    end

    // level is live, never latched; frozen outside normal/stop and on gated pins
    always_comb begin
        for (int k = 0; k < WKM_NPIN; k++) begin
            if (active_mode && !gated[k]) begin
                next_lvl[k] = flt_level[k];
            end else begin
                next_lvl[k] = O_LEVEL[k];
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_STATUS_A <= '0;
            O_STATUS_B <= '0;
            O_LEVEL <= '0;
            O_INT_REQ <= 1'b0;
            O_WAKE_REQ <= 1'b0;
        end else if (I_CE) begin
            O_STATUS_A <= next_stat_a;
            O_STATUS_B <= next_stat_b;
            O_LEVEL <= next_lvl;
            O_INT_REQ <= next_int;
            O_WAKE_REQ <= next_wake;
        end
    end

    // ------------------------------------------------------------
    // pull sources, switch and sleep check
    // ------------------------------------------------------------
    logic [WKM_NPIN-1:0] next_pu, next_pd;
    logic next_sw, next_fail, bad_sleep;

    // auto mode follows the accepted level, not the raw pin
    always_comb begin
        for (int k = 0; k < WKM_NPIN; k++) begin
            case (cfg.pull[k*WKM_FLD_W +: WKM_FLD_W])
                WKM_PULL_NONE: begin
                    next_pu[k] = 1'b0;
                    next_pd[k] = 1'b0;
                end
                WKM_PULL_DOWN: begin
                    next_pu[k] = 1'b0;
                    next_pd[k] = 1'b1;
                end
                WKM_PULL_UP: begin
                    next_pu[k] = 1'b1;
                    next_pd[k] = 1'b0;
                end
                WKM_PULL_AUTO: begin
                    next_pu[k] = flt_level[k];
                    next_pd[k] = !flt_level[k];
                end
                default: begin
                    next_pu[k] = 1'b0;
                    next_pd[k] = 1'b0;
                end
            endcase
            if (gated[k]) begin
                next_pu[k] = 1'b0;
                next_pd[k] = 1'b0;
            end
        end
    end

    // other wake sources lie outside this block; only ours count
    always_comb begin
        next_sw = cfg.meas && (I_MODE == WKM_MODE_NORMAL);
        bad_sleep = cfg.meas && (|cfg.wen[1:0]) && !cfg.wen[2] &&
                    !(|I_AFO_WAKE_EN);
        next_fail = I_SLEEP_CMD && bad_sleep;
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_PULL_UP_EN <= '0;
            O_PULL_DOWN_EN <= '0;
            O_SWITCH_CLOSED <= 1'b0;
            O_SPI_FAIL <= 1'b0;
            O_RESTART_REQ <= 1'b0;
        end else if (I_CE) begin
            O_PULL_UP_EN <= next_pu;
            O_PULL_DOWN_EN <= next_pd;
            O_SWITCH_CLOSED <= next_sw;
            O_SPI_FAIL <= next_fail;
            O_RESTART_REQ <= next_fail;
        end
    end

    // readback straight from the stored settings
    always_comb begin
        O_PULL_CFG = cfg.pull;
        O_DET_CFG = cfg.det;
        O_WEN_CFG = cfg.wen;
        O_MEAS_CFG = cfg.meas;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_bad_sleep;
        I_CE && I_SLEEP_CMD && bad_sleep;
    endsequence

    sequence s_fail_out;
        O_SPI_FAIL && O_RESTART_REQ;
    endsequence

    property p_sleep_fail;
        @(posedge I_MCLK) disable iff (I_RST)
        s_bad_sleep |=> s_fail_out;
    endproperty
    a_sleep_fail: assert property (p_sleep_fail)
        else $error("bad sleep not flagged");

    property p_switch_open;
        @(posedge I_MCLK) disable iff (I_RST)
        (I_CE && (!cfg.meas || I_MODE != WKM_MODE_NORMAL))
            |=> !O_SWITCH_CLOSED;
    endproperty
    a_switch_open: assert property (p_switch_open)
        else $error("switch closed outside normal measurement");

    property p_gate_pull;
        @(posedge I_MCLK) disable iff (I_RST)
        (I_CE && cfg.meas) |=>
            (O_PULL_UP_EN[1:0] == 2'h0) && (O_PULL_DOWN_EN[1:0] == 2'h0);
    endproperty
    a_gate_pull: assert property (p_gate_pull)
        else $error("pull active on gated pin");

    property p_sticky;
        @(posedge I_MCLK) disable iff (I_RST)
        I_CE |=> ((O_STATUS_A & $past(O_STATUS_A & ~I_STAT_A_CLR))
            == $past(O_STATUS_A & ~I_STAT_A_CLR));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("wake flag lost without clear");

    property p_int_mode;
        @(posedge I_MCLK) disable iff (I_RST)
        O_INT_REQ |-> $past(active_mode) &&
            ((|O_STATUS_A) || (|O_STATUS_B));
    endproperty
    a_int_mode: assert property (p_int_mode)
        else $error("interrupt outside normal or stop");

    property p_wake_mode;
        @(posedge I_MCLK) disable iff (I_RST)
        O_WAKE_REQ |-> $past(low_power) && !O_INT_REQ;
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("wake outside sleep or failsafe");

    property p_disabled;
        @(posedge I_MCLK) disable iff (I_RST)
        (I_CE && !cfg.wen[2] && !O_STATUS_A[2]) |=> !O_STATUS_A[2];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled pin set its flag");

    property p_pull_reset;
        @(posedge I_MCLK)
        I_RST |=> (O_PULL_CFG == WKM_PULL_RST) && !O_MEAS_CFG;
    endproperty
    a_pull_reset: assert property (p_pull_reset)
        else $error("pull selection not cleared by reset");
endmodule
`default_nettype wire

// ---- testbench/wkm_pin_model.sv ----
// switches on the wake pins, with pull fallback when open
`timescale 1ns/100ps
`default_nettype none
module wkm_pin_model (
    // clock and switch control
    input wire logic i_clk,
    input wire logic [2:0] i_closed,
    input wire logic [2:0] i_val,
    // pull sources from the block
    input wire logic [2:0] i_pu,
    input wire logic [2:0] i_pd,
    // pin levels
    output logic [2:0] o_pin
);
    logic flt = 1'b0;

    // an open pin with no pull wanders, so toggle it every cycle
    always @(posedge i_clk) begin
        flt <= ~flt;
    end

    // closed switch wins, else the pull, else the wandering level
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            o_pin[k] = i_closed[k] ? i_val[k] :
                i_pu[k] ? 1'b1 : i_pd[k] ? 1'b0 : flt;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_wake_input_monitor.sv ----
// self-checking bench for the wake input monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, g); fails++; end end
module test_wake_input_monitor
    import wkm_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pval = 3'h0;
    logic [1:0] afo = 2'h0;
    logic [1:0] afo_en = 2'h0;
    logic [1:0] win = 2'h0;
    wkm_mode_e mode = WKM_MODE_NORMAL;
    logic sleep = 1'b0;
    logic [3:0] wr = 4'h0;
    logic [5:0] p = 6'h00;
    logic [5:0] d = 6'h00;
    logic [2:0] w = 3'h0;
    logic m = 1'b0;
    logic [4:0] clr = 5'h00;
    logic [4:0] st;
    logic [2:0] pin, pu, pd, lvl, wc;
    logic [5:0] pc, dc;
    logic mc, sw, irq, wake, fail, rs;
    int fails = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    // --------------------------------------------------------------
    // block and pin partner
    // --------------------------------------------------------------
    wkm_pin_model pins_u (.i_clk(clk), .i_closed(3'h7), .i_val(pval),
        .i_pu(pu), .i_pd(pd), .o_pin(pin));
    wkm_top dut_u (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1),
        .I_WAKE_PIN(pin), .I_AFO_PIN(afo), .I_MODE(mode),
        .I_TIMER_WIN(win), .I_AFO_WAKE_EN(afo_en), .I_SLEEP_CMD(sleep),
        .I_PULL_WR(wr[0]), .I_PULL_DATA(p), .I_DET_WR(wr[1]),
        .I_DET_DATA(d), .I_WEN_WR(wr[2]), .I_WEN_DATA(w),
        .I_MEAS_WR(wr[3]), .I_MEAS_DATA(m), .I_STAT_A_CLR(clr[2:0]),
        .I_STAT_B_CLR(clr[4:3]), .O_PULL_CFG(pc), .O_DET_CFG(dc),
        .O_WEN_CFG(wc), .O_MEAS_CFG(mc), .O_STATUS_A(st[2:0]),
        .O_STATUS_B(st[4:3]), .O_LEVEL(lvl), .O_PULL_UP_EN(pu),
        .O_PULL_DOWN_EN(pd), .O_SWITCH_CLOSED(sw), .O_INT_REQ(irq),
        .O_WAKE_REQ(wake), .O_SPI_FAIL(fail), .O_RESTART_REQ(rs));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // all four settings in one cycle, then read them back
    task automatic cfg(input logic [5:0] np, input logic [5:0] nd,
                       input logic [2:0] nw, input logic nm);
        @(posedge clk);
        {p, d, w, m} <= {np, nd, nw, nm};
        wr <= 4'hf;
        @(posedge clk);
        wr <= 4'h0;
        #1;
        `CHK("cfg", {np, nd, nw, nm}, {pc, dc, wc, mc})
    endtask

    // index 0..2 are wake pins, 3..4 alternate outputs
    task automatic flip(input int k);
        @(posedge clk);
        if (k < 3) pval[k] <= ~pval[k];
        else afo[k-3] <= ~afo[k-3];
    endtask

    // wait for flag k, check delay, pulses, stickiness, then clear
    task automatic hit(input int k, input int lo, input logic xi,
                       input logic xw);
        int c;
        c = 0;
        #1;
        while (st[k] !== 1'b1 && c < lo + 20) begin
            @(posedge clk);
            #1;
            c++;
        end
        `CHK("delay", 1'b1, c >= lo && c <= lo + 10)
        if (c >= lo + 20) complete_run();
        `CHK("int", xi, irq)
        `CHK("wake", xw, wake)
        @(posedge clk);
        #1;
        `CHK("pulse_end", 1'b0, irq | wake)
        `CHK("sticky", 1'b1, st[k])
        @(posedge clk);
        clr[k] <= 1'b1;
        @(posedge clk);
        clr[k] <= 1'b0;
        #1;
        `CHK("cleared", 1'b0, st[k])
    endtask

    // n cycles with neither pulse nor flag k
    task automatic quiet(input int k, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | irq | wake | st[k];
        end
        `CHK("quiet", 1'b0, seen)
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_edges;
        cfg(6'h00, 6'h00, 3'h7, 1'b0);
        flip(0);
        hit(0, 800, 1'b1, 1'b0);
        `CHK("lvl", 1'b1, lvl[0])
        @(posedge clk);
        mode <= WKM_MODE_SLEEP;
        flip(0);
        hit(0, 800, 1'b0, 1'b1);
        `CHK("lvl_held", 1'b1, lvl[0])
        @(posedge clk);
        mode <= WKM_MODE_FAILSAFE;
        flip(0);
        hit(0, 800, 1'b0, 1'b1);
        @(posedge clk);
        mode <= WKM_MODE_STOP;
        flip(0);
        hit(0, 800, 1'b1, 1'b0);
    endtask

    task automatic t_filter;
        flip(1);
        tick(500);
        flip(1);
        quiet(1, 500);
        flip(1);
        hit(1, 800, 1'b1, 1'b0);
        cfg(6'h00, 6'h04, 3'h3, 1'b0);
        flip(1);
        hit(1, 3200, 1'b1, 1'b0);
        flip(2);
        quiet(2, 820);
        `CHK("lvl_dis", 1'b1, lvl[2])
    endtask

    task automatic t_pulls;
        for (int i = 0; i < 4; i++) begin
            cfg({3{i[1:0]}}, 6'h00, 3'h7, 1'b0);
            tick(1);
            #1;
            `CHK("pu", i == 2 ? 3'h7 : i == 3 ? pval : 3'h0, pu)
            `CHK("pd", i == 1 ? 3'h7 : i == 3 ? ~pval : 3'h0, pd)
        end
    endtask

    task automatic t_meas;
        // switch may only close in normal mode, so leave stop first
        @(posedge clk);
        mode <= WKM_MODE_NORMAL;
        cfg(6'h3f, 6'h00, 3'h3, 1'b1);
        tick(1);
        #1;
        `CHK("sw_on", 1'b1, sw)
        `CHK("pull_off", 2'h0, pu[1:0] | pd[1:0])
        @(posedge clk);
        mode <= WKM_MODE_STOP;
        tick(1);
        #1;
        `CHK("sw_stop", 1'b0, sw)
        flip(0);
        quiet(0, 820);
        `CHK("lvl_gate", 1'b0, lvl[0])
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        #1;
        `CHK("fail", 2'h3, {fail, rs})
        flip(0);
        mode <= WKM_MODE_NORMAL;
        cfg(6'h3f, 6'h08, 3'h7, 1'b0);
    endtask

    task automatic t_cyclic;
        flip(1);
        quiet(1, 900);
        @(posedge clk);
        win <= 2'h1; // timer one window powers the sensor
        hit(1, 800, 1'b1, 1'b0);
        cfg(6'h3f, 6'h0c, 3'h7, 1'b0);
        flip(1);
        quiet(1, 900);
        @(posedge clk);
        win <= 2'h2;
        hit(1, 800, 1'b1, 1'b0);
        @(posedge clk);
        afo_en <= 2'h3;
        flip(4);
        hit(4, 800, 1'b1, 1'b0);
    endtask

    initial begin
        tick(12);
        rst <= 1'b0;
        #1;
        `CHK("rst_cfg", 16'h0000, {pc, dc, wc, mc})
        `CHK("rst_sw", 1'b0, sw)
        t_edges();
        t_filter();
        t_pulls();
        t_meas();
        t_cyclic();
        complete_run();
    end
endmodule
`default_nettype wire
